// ===== core/pad_input_sync.sv
// two-stage synchroniser for one pad input
`timescale 1ns/1ps
`default_nettype none

module pad_input_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // pad side
  input  wire logic pad_i,
  // core side
  output var  logic sync_o
);

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic meta;  // first stage, read only by the second
    logic held;  // second stage, safe to use
  } sync_s;

  sync_s st_r;   // registered state
  sync_s st_nxt; // next state

  // shift the pad level one stage per clock
  always_comb begin
    st_nxt      = st_r;
    st_nxt.meta = pad_i;
    st_nxt.held = st_r.meta;
  end

  // both stages clear on reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_o = st_r.held;

endmodule // pad_input_sync

`default_nettype wire

// ===== core/pin_multiplexer.sv
// pin multiplexer between port bits and peripheral functions
`timescale 1ns/1ps
`default_nettype none

// Function
// - enabled peripheral output overrides port output
// - pulse pin carries waveform while enabled
// - serial clock first, timer next, else port
// - serial data pin driven while enabled
// - serial input always fed to receiver
// - dma request routed only when selected
// - dma accept driven only when enabled
// - dma end driven only when enabled
// - analog pin goes to converter when selected
// - d/a output presented only when enabled
// - pull-up, open-drain, standby input gating
module pin_multiplexer (
  // clock and reset
  input  wire logic                                SYS_CLK,
  input  wire logic                                RESETN,
  // register port
  input  wire logic [pinmux_pkg::ADDR_W-1:0]       REG_ADDR,
  input  wire logic [pinmux_pkg::WORD_W-1:0]       REG_WDATA,
  input  wire logic                                REG_WR,
  input  wire logic                                REG_RD,
  output var  logic [pinmux_pkg::WORD_W-1:0]       REG_RDATA,
  // low-power control
  input  wire logic                                STANDBY,
  // peripheral outputs toward the pins
  input  wire logic [pinmux_pkg::N_PG-1:0]         PULSE_GEN_WAVE,
  input  wire logic [pinmux_pkg::N_SER-1:0]        SERIAL_CLOCK_OUT,
  input  wire logic [pinmux_pkg::N_SER-1:0]        RELOAD_TIMER_OUT,
  input  wire logic [pinmux_pkg::N_SER-1:0]        SERIAL_TX_DATA,
  input  wire logic [pinmux_pkg::N_DACK-1:0]       DMA_ACCEPT,
  input  wire logic [pinmux_pkg::N_DEND-1:0]       DMA_END,
  // pin inputs toward the peripherals
  output var  logic [pinmux_pkg::N_SER-1:0]        SERIAL_RX_DATA,
  output var  logic [pinmux_pkg::N_SER-1:0]        SERIAL_CLOCK_IN,
  output var  logic [pinmux_pkg::N_DREQ-1:0]       DMA_REQUEST,
  // analog switches
  output var  logic [pinmux_pkg::N_AN-1:0]         ANALOG_SWITCH,
  output var  logic [pinmux_pkg::N_DAC-1:0]        DAC_OUT_ENABLE,
  // pads
  input  wire logic [pinmux_pkg::NPIN-1:0]         PAD_I,
  output var  logic [pinmux_pkg::NPIN-1:0]         PAD_O,
  output var  logic [pinmux_pkg::NPIN-1:0]         PAD_OE_N,
  output var  logic [pinmux_pkg::NPIN-1:0]         PAD_PULLUP
);

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic [pinmux_pkg::N_KIND-1:0][pinmux_pkg::NPIN-1:0] vreg; // per pin
    logic [pinmux_pkg::FUNC_W-1:0] func;   // function enables
    logic [pinmux_pkg::N_AN-1:0]   asel;   // analog pin select
    logic [pinmux_pkg::N_DAC-1:0]  dac;    // d/a output enables
    logic [pinmux_pkg::WORD_W-1:0] rdata;  // read answer
    logic [pinmux_pkg::NPIN-1:0]   pad_o;
    logic [pinmux_pkg::NPIN-1:0]   pad_oe_n;
    logic [pinmux_pkg::NPIN-1:0]   pad_pu;
    logic [pinmux_pkg::N_SER-1:0]  rx;
    logic [pinmux_pkg::N_SER-1:0]  sclk_in;
    logic [pinmux_pkg::N_DREQ-1:0] dreq;
    logic [pinmux_pkg::N_AN-1:0]   asw;
    logic [pinmux_pkg::N_DAC-1:0]  dac_en;
  } state_s;

  state_s st_r;   // registered state
  state_s st_nxt; // next state
  logic [pinmux_pkg::NPIN-1:0] pad_sync;  // synchronised pad levels
  logic [pinmux_pkg::NPIN-1:0] pad_in;    // after standby gating
  logic [pinmux_pkg::NPIN-1:0] fn_drive;  // peripheral owns the pin
  logic [pinmux_pkg::NPIN-1:0] fn_val;    // peripheral output level
  logic [pinmux_pkg::NPIN-1:0] an_pin;    // pin handed to the converter

  // ***************************************************************
  // pad input synchronisers
  // ***************************************************************
  // pads are asynchronous to the core clock
  generate
    for (genvar gi = 0; gi < pinmux_pkg::NPIN; gi++) begin : g_sync
      pad_input_sync u_sync (
        .clk    (SYS_CLK),
        .rstn   (RESETN),
        .pad_i  (PAD_I[gi]),
        .sync_o (pad_sync[gi])
      );
    end
  endgenerate

  // ***************************************************************
  // function ownership of each pin
  // ***************************************************************
  // pins of one group are contiguous, so a loop per group serves
  always_comb begin
    fn_drive = '0;
    fn_val   = '0;
    an_pin   = '0;
    // pulse generator pins
    for (int i = 0; i < pinmux_pkg::N_PG; i++) begin
      fn_drive[pinmux_pkg::BASE_PG+i] = st_r.func[pinmux_pkg::FN_PG+i];
      fn_val[pinmux_pkg::BASE_PG+i]   = PULSE_GEN_WAVE[i];
    end
    // serial clock pins shared with reload timers
    for (int i = 0; i < pinmux_pkg::N_SER; i++) begin
      if (st_r.func[pinmux_pkg::FN_SCK+i]) begin
        // serial clock wins even if the timer is enabled too
        fn_drive[pinmux_pkg::BASE_SCK+i] = 1'b1;
        fn_val[pinmux_pkg::BASE_SCK+i]   = SERIAL_CLOCK_OUT[i];
      end else if (st_r.func[pinmux_pkg::FN_TMR+i]) begin
        fn_drive[pinmux_pkg::BASE_SCK+i] = 1'b1;
        fn_val[pinmux_pkg::BASE_SCK+i]   = RELOAD_TIMER_OUT[i];
      end
      // serial data output pin of the same channel
      fn_drive[pinmux_pkg::BASE_TX+i] = st_r.func[pinmux_pkg::FN_TX+i];
      fn_val[pinmux_pkg::BASE_TX+i]   = SERIAL_TX_DATA[i];
    end
    // dma accept pins
    for (int i = 0; i < pinmux_pkg::N_DACK; i++) begin
      fn_drive[pinmux_pkg::BASE_DACK+i] = st_r.func[pinmux_pkg::FN_DACK+i];
      fn_val[pinmux_pkg::BASE_DACK+i]   = DMA_ACCEPT[i];
    end
    // dma end pins
    for (int i = 0; i < pinmux_pkg::N_DEND; i++) begin
      fn_drive[pinmux_pkg::BASE_DEND+i] = st_r.func[pinmux_pkg::FN_DEND+i];
      fn_val[pinmux_pkg::BASE_DEND+i]   = DMA_END[i];
    end
    // analog pins have no digital function, only the switch
    for (int i = 0; i < pinmux_pkg::N_AN; i++) begin
      an_pin[pinmux_pkg::BASE_AN+i] = st_r.asel[i];
    end
  end
  // ***************************************************************
  // standby gating of the input path
  // ***************************************************************
  // a gated input reads low so the hysteresis stage sees no toggling;
  // a selected analog pin never feeds the digital path
  always_comb begin
    for (int i = 0; i < pinmux_pkg::NPIN; i++) begin
      pad_in[i] = pad_sync[i] & ~an_pin[i]
                & ~(STANDBY & ~st_r.vreg[pinmux_pkg::KIND_STK][i]);
    end
  end
  // ***************************************************************
  // next state: register port, pad drivers, peripheral inputs
  // ***************************************************************
  always_comb begin
    logic [pinmux_pkg::NPIN-1:0] drv;  // pin is being driven
    logic [pinmux_pkg::NPIN-1:0] val;  // level offered to the pin
    drv    = '0;
    val    = '0;
    st_nxt = st_r;
    // register writes, one word per strobe
    if (REG_WR) begin
      if (REG_ADDR < pinmux_pkg::ADDR_VREG_END) begin
        if (REG_ADDR[0]) begin
          // high word: only the pads above bit 31 exist
          st_nxt.vreg[REG_ADDR[pinmux_pkg::ADDR_W-1:1]]
                     [pinmux_pkg::NPIN-1:pinmux_pkg::WORD_W] =
            REG_WDATA[pinmux_pkg::HI_W-1:0];
        end else begin
          st_nxt.vreg[REG_ADDR[pinmux_pkg::ADDR_W-1:1]]
                     [pinmux_pkg::WORD_W-1:0] = REG_WDATA;
        end
      end else begin
        case (REG_ADDR)
          pinmux_pkg::ADDR_FUNC: begin
            st_nxt.func = REG_WDATA[pinmux_pkg::FUNC_W-1:0];
          end
          pinmux_pkg::ADDR_ASEL: begin
            st_nxt.asel = REG_WDATA[pinmux_pkg::N_AN-1:0];
          end
          pinmux_pkg::ADDR_DAC: begin
            st_nxt.dac = REG_WDATA[pinmux_pkg::N_DAC-1:0];
          end
          default: begin
            // pin level words are read-only, others unmapped
          end
        endcase
      end
    end
    // read answer stands for exactly the cycle after the strobe
    st_nxt.rdata = '0;
    if (REG_RD) begin
      if (REG_ADDR < pinmux_pkg::ADDR_VREG_END) begin
        if (REG_ADDR[0]) begin
          st_nxt.rdata[pinmux_pkg::HI_W-1:0] =
            st_r.vreg[REG_ADDR[pinmux_pkg::ADDR_W-1:1]]
                     [pinmux_pkg::NPIN-1:pinmux_pkg::WORD_W];
        end else begin
          st_nxt.rdata = st_r.vreg[REG_ADDR[pinmux_pkg::ADDR_W-1:1]]
                                  [pinmux_pkg::WORD_W-1:0];
        end
      end else begin
        case (REG_ADDR)
          pinmux_pkg::ADDR_PIN_LO: begin
            st_nxt.rdata = pad_in[pinmux_pkg::WORD_W-1:0];
          end
          pinmux_pkg::ADDR_PIN_HI: begin
            st_nxt.rdata[pinmux_pkg::HI_W-1:0] =
              pad_in[pinmux_pkg::NPIN-1:pinmux_pkg::WORD_W];
          end
          pinmux_pkg::ADDR_FUNC: begin
            st_nxt.rdata[pinmux_pkg::FUNC_W-1:0] = st_r.func;
          end
          pinmux_pkg::ADDR_ASEL: begin
            st_nxt.rdata[pinmux_pkg::N_AN-1:0] = st_r.asel;
          end
          pinmux_pkg::ADDR_DAC: begin
            st_nxt.rdata[pinmux_pkg::N_DAC-1:0] = st_r.dac;
          end
          default: begin
            // unmapped words read as zero
          end
        endcase
      end
    end
    // pad drivers: peripheral first, port bits otherwise
    for (int i = 0; i < pinmux_pkg::NPIN; i++) begin
      if (fn_drive[i]) begin
        drv[i] = 1'b1;
        val[i] = fn_val[i];
      end else begin
        drv[i] = st_r.vreg[pinmux_pkg::KIND_DIR][i] & ~an_pin[i];
        val[i] = st_r.vreg[pinmux_pkg::KIND_DATA][i];
      end
      // open drain only ever pulls low; a high level floats
      st_nxt.pad_o[i]    = val[i];
      st_nxt.pad_oe_n[i] = ~(drv[i]
        & ~(st_r.vreg[pinmux_pkg::KIND_OD][i] & val[i]));
      // pull-up off on selected analog pins so it cannot bias the converter
      st_nxt.pad_pu[i]   = st_r.vreg[pinmux_pkg::KIND_PU][i]
                         & ~an_pin[i];
    end
    // serial inputs run all the time, the receiver decides use
    for (int i = 0; i < pinmux_pkg::N_SER; i++) begin
      st_nxt.rx[i]      = pad_in[pinmux_pkg::BASE_RX+i];
      st_nxt.sclk_in[i] = pad_in[pinmux_pkg::BASE_SCK+i];
    end
    // dma requests reach the controller only while selected
    for (int i = 0; i < pinmux_pkg::N_DREQ; i++) begin
      st_nxt.dreq[i] = pad_in[pinmux_pkg::BASE_DREQ+i]
                     & st_r.func[pinmux_pkg::FN_DREQ+i];
    end
    st_nxt.asw    = st_r.asel;
    st_nxt.dac_en = st_r.dac;
  end
  // ***************************************************************
  // state register
  // ***************************************************************
  // reset leaves every pin as an undriven input with no function
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_r          <= '0;
      st_r.vreg     <= {pinmux_pkg::N_KIND{pinmux_pkg::RST_PINREG}};
      st_r.func     <= pinmux_pkg::RST_FUNC;
      st_r.asel     <= pinmux_pkg::RST_ASEL;
      st_r.dac      <= pinmux_pkg::RST_DAC;
      st_r.pad_oe_n <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end
  // ***************************************************************
  // outputs, all straight from the state register
  // ***************************************************************
  assign REG_RDATA       = st_r.rdata;
  assign PAD_O           = st_r.pad_o;
  assign PAD_OE_N        = st_r.pad_oe_n;
  assign PAD_PULLUP      = st_r.pad_pu;
  assign SERIAL_RX_DATA  = st_r.rx;
  assign SERIAL_CLOCK_IN = st_r.sclk_in;
  assign DMA_REQUEST     = st_r.dreq;
  assign ANALOG_SWITCH   = st_r.asw;
  assign DAC_OUT_ENABLE  = st_r.dac_en;
  // ***************************************************************
  // checks on channel 0 of each group except dma end and d/a
  // ***************************************************************
  a_pg_wave_out: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    st_r.func[pinmux_pkg::FN_PG] && !st_r.vreg[pinmux_pkg::KIND_OD][0]
    |=> !PAD_OE_N[pinmux_pkg::BASE_PG]
        && PAD_O[pinmux_pkg::BASE_PG] == $past(PULSE_GEN_WAVE[0]))
    else $error("pulse pin lost its waveform");
  a_sclk_first: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    st_r.func[pinmux_pkg::FN_SCK] && st_r.func[pinmux_pkg::FN_TMR]
    |=> PAD_O[pinmux_pkg::BASE_SCK] == $past(SERIAL_CLOCK_OUT[0]))
    else $error("timer beat serial clock");
  a_timer_out: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    !st_r.func[pinmux_pkg::FN_SCK] && st_r.func[pinmux_pkg::FN_TMR]
    |=> PAD_O[pinmux_pkg::BASE_SCK] == $past(RELOAD_TIMER_OUT[0]))
    else $error("timer not on clock pin");
  a_tx_port_back: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    !st_r.func[pinmux_pkg::FN_TX]
    |=> PAD_O[pinmux_pkg::BASE_TX]
        == $past(st_r.vreg[pinmux_pkg::KIND_DATA][pinmux_pkg::BASE_TX]))
    else $error("tx pin not back to port");
  a_rx_path_delay: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    !STANDBY && $past(RESETN, 3)
    |=> SERIAL_RX_DATA[0] == $past(PAD_I[pinmux_pkg::BASE_RX], 3))
    else $error("rx input not fed through");
  a_dreq_blocked: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    !st_r.func[pinmux_pkg::FN_DREQ] |=> !DMA_REQUEST[0])
    else $error("unselected dma request passed");
  a_dack_follow: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    st_r.func[pinmux_pkg::FN_DACK]
    |=> PAD_O[pinmux_pkg::BASE_DACK] == $past(DMA_ACCEPT[0]))
    else $error("accept pin wrong");
  a_analog_quiet: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    st_r.asel[0]
    |=> ANALOG_SWITCH[0] && PAD_OE_N[pinmux_pkg::BASE_AN]
        && !PAD_PULLUP[pinmux_pkg::BASE_AN])
    else $error("analog pin still digital");
  a_od_release: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    st_r.vreg[pinmux_pkg::KIND_OD][pinmux_pkg::BASE_PG]
    |=> PAD_OE_N[pinmux_pkg::BASE_PG] || !PAD_O[pinmux_pkg::BASE_PG])
    else $error("open drain drove high");
  a_read_once: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    !REG_RD |=> REG_RDATA == '0)
    else $error("read data outside its cycle");

endmodule // pin_multiplexer

`default_nettype wire

// ===== core/pinmux_pkg.sv
// constants shared by the pin multiplexer and the board model
package pinmux_pkg;

  // ***************************************************************
  // pin counts per function group
  // ***************************************************************
  localparam int N_PG   = 6;   // pulse generator outputs
  localparam int N_SER  = 4;   // serial channels
  localparam int N_DREQ = 3;   // dma request inputs
  localparam int N_DACK = 3;   // dma accept outputs
  localparam int N_DEND = 2;   // dma end outputs
  localparam int N_AN   = 8;   // analog inputs
  localparam int N_DAC  = 3;   // d/a outputs

  // ***************************************************************
  // pad index of the first pin of each group
  // ***************************************************************
  localparam int BASE_PG   = 0;
  localparam int BASE_SCK  = BASE_PG + N_PG;
  localparam int BASE_TX   = BASE_SCK + N_SER;
  localparam int BASE_RX   = BASE_TX + N_SER;
  localparam int BASE_DREQ = BASE_RX + N_SER;
  localparam int BASE_DACK = BASE_DREQ + N_DREQ;
  localparam int BASE_DEND = BASE_DACK + N_DACK;
  localparam int BASE_AN   = BASE_DEND + N_DEND;
  localparam int NPIN      = BASE_AN + N_AN;   // 34 pads
  localparam int WORD_W    = 32;
  localparam int HI_W      = NPIN - WORD_W;    // pads above the low word

  // ***************************************************************
  // function enable register fields
  // ***************************************************************
  localparam int FN_PG   = 0;              // pulse generator enables
  localparam int FN_SCK  = FN_PG + N_PG;   // serial clock output enables
  localparam int FN_TMR  = FN_SCK + N_SER; // reload timer output enables
  localparam int FN_TX   = FN_TMR + N_SER; // serial data output enables
  localparam int FN_DREQ = FN_TX + N_SER;  // dma request source selects
  localparam int FN_DACK = FN_DREQ + N_DREQ;
  localparam int FN_DEND = FN_DACK + N_DACK;
  localparam int FUNC_W  = FN_DEND + N_DEND;

  // ***************************************************************
  // per-pin register kinds, each a low and a high word
  // ***************************************************************
  localparam int N_KIND    = 5;
  localparam int KIND_DATA = 0;  // port output value
  localparam int KIND_DIR  = 1;  // port direction, 1 = output
  localparam int KIND_PU   = 2;  // pull-up enable
  localparam int KIND_OD   = 3;  // open-drain enable
  localparam int KIND_STK  = 4;  // keep input alive in standby

  // ***************************************************************
  // word addresses on the register port
  // ***************************************************************
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] ADDR_VREG_END = 5'h0A; // below: kinds
  localparam logic [ADDR_W-1:0] ADDR_PIN_LO   = 5'h0A;
  localparam logic [ADDR_W-1:0] ADDR_PIN_HI   = 5'h0B;
  localparam logic [ADDR_W-1:0] ADDR_FUNC     = 5'h0C;
  localparam logic [ADDR_W-1:0] ADDR_ASEL     = 5'h0D;
  localparam logic [ADDR_W-1:0] ADDR_DAC      = 5'h0E;

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [NPIN-1:0]   RST_PINREG = '0;
  localparam logic [FUNC_W-1:0] RST_FUNC   = '0;
  localparam logic [N_AN-1:0]   RST_ASEL   = '0;
  localparam logic [N_DAC-1:0]  RST_DAC    = '0;

endpackage

// ===== verif/board_model.sv
// board model: resolves each pad from device drive, pull-up or board level
`timescale 1ns/1ps
`default_nettype none

module board_model (
  // pads from the device
  input  wire logic [pinmux_pkg::NPIN-1:0] pad_o,
  input  wire logic [pinmux_pkg::NPIN-1:0] pad_oe_n,
  input  wire logic [pinmux_pkg::NPIN-1:0] pad_pullup,
  // level the board puts on each pin the device releases
  input  wire logic [pinmux_pkg::NPIN-1:0] ext_level,
  // resolved levels back to the device
  output var  logic [pinmux_pkg::NPIN-1:0] pad_i
);
  // **************************************************************
  // wire resolution
  // **************************************************************
  // device drive wins; a released pin goes to the pull-up, else the
  // board level, which the bench changes every round so no stale value
  always_comb begin
    for (int i = 0; i < pinmux_pkg::NPIN; i++) begin
      pad_i[i] = !pad_oe_n[i] ? pad_o[i] : (pad_pullup[i] | ext_level[i]);
    end
  end
endmodule // board_model

`default_nettype wire

// ===== verif/peripheral_pin_multiplexer_tb.sv
// self-checking bench for the pin multiplexer
`timescale 1ns/1ps
`default_nettype none

module peripheral_pin_multiplexer_tb;
  // **************************************************************
  // stimulus, observation and mirror state
  // **************************************************************
  logic        clk = 1'b0;            // 50 MHz system clock
  logic        rstn = 1'b0;           // active-low reset
  logic [4:0]  addr = '0;             // register word address
  logic [31:0] wdata = '0;            // write data
  logic [31:0] rdata;                 // read data
  logic [31:0] rnd;                   // scratch random word
  logic        wr = 1'b0;             // write strobe
  logic        rd = 1'b0;             // read strobe
  logic        stby = 1'b0;           // standby level
  logic [5:0]  pg = '0;               // pulse waveforms
  logic [3:0]  sck = '0, tmr = '0, tx = '0, rxd, sckin;
  logic [2:0]  acc = '0, dreq, dac;
  logic [1:0]  dend = '0;
  logic [7:0]  asw;
  logic [33:0] pin_i, po, poen, ppu, ext = '0;
  logic [33:0] kind_m [5];            // per-pin kinds as written
  logic [25:0] func_m;                // function enables
  logic [7:0]  asel_m;                // analog selects
  logic [2:0]  dac_m;                 // d/a enables
  int          seed = 52720;
  int          n_mismatch = 0;
  int          checks = 0;

  always #10 clk = ~clk;

  pin_multiplexer i_dut (.SYS_CLK(clk), .RESETN(rstn), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .STANDBY(stby), .PULSE_GEN_WAVE(pg), .SERIAL_CLOCK_OUT(sck),
    .RELOAD_TIMER_OUT(tmr), .SERIAL_TX_DATA(tx), .DMA_ACCEPT(acc),
    .DMA_END(dend), .SERIAL_RX_DATA(rxd), .SERIAL_CLOCK_IN(sckin),
    .DMA_REQUEST(dreq), .ANALOG_SWITCH(asw), .DAC_OUT_ENABLE(dac),
    .PAD_I(pin_i), .PAD_O(po), .PAD_OE_N(poen), .PAD_PULLUP(ppu));
  board_model i_board (.pad_o(po), .pad_oe_n(poen), .pad_pullup(ppu),
    .ext_level(ext), .pad_i(pin_i));

  // **************************************************************
  // bus tasks and comparison
  // **************************************************************
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one-cycle write; the mirror keeps only implemented bits
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    if (a < 5'h0A && !a[0]) kind_m[a[4:1]][31:0] = d;
    else if (a < 5'h0A) kind_m[a[4:1]][33:32] = d[1:0];
    else if (a == 5'h0C) func_m = d[25:0];
    else if (a == 5'h0D) asel_m = d[7:0];
    else if (a == 5'h0E) dac_m = d[2:0];
  endtask

  // read data is taken in the single cycle it stands
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 cmp(64'(rdata), 64'(e));
  endtask

  function automatic logic [31:0] reg_exp(input logic [4:0] a);
    if (a < 5'h0A) return a[0] ? {30'h0, kind_m[a[4:1]][33:32]}
                               : kind_m[a[4:1]][31:0];
    if (a == 5'h0C) return {6'h0, func_m};
    if (a == 5'h0D) return {24'h0, asel_m};
    if (a == 5'h0E) return {29'h0, dac_m};
    return 32'h0;  // unmapped words read zero
  endfunction

  // every word except the live pin levels, checked elsewhere
  task automatic rd_all();
    for (int a = 0; a < 32; a++)
      if (a != 10 && a != 11) rd_chk(5'(a), reg_exp(5'(a)));
  endtask

  // **************************************************************
  // reference model of the pads, compared after pipelines settle
  // **************************************************************
  task automatic check_all();
    logic [33:0] o, oen, pu, lvl, g;
    repeat (6) @(posedge clk);
    #1;
    o = kind_m[0];
    oen = ~kind_m[1];
    pu = kind_m[2];
    for (int c = 0; c < 6; c++)
      if (func_m[c]) {o[c], oen[c]} = {pg[c], 1'b0};
    for (int c = 0; c < 4; c++) begin
      if (func_m[6+c]) {o[6+c], oen[6+c]} = {sck[c], 1'b0};
      else if (func_m[10+c]) {o[6+c], oen[6+c]} = {tmr[c], 1'b0};
      if (func_m[14+c]) {o[10+c], oen[10+c]} = {tx[c], 1'b0};
    end
    for (int c = 0; c < 3; c++)
      if (func_m[21+c]) {o[21+c], oen[21+c]} = {acc[c], 1'b0};
    for (int c = 0; c < 2; c++)
      if (func_m[24+c]) {o[24+c], oen[24+c]} = {dend[c], 1'b0};
    oen = oen | (kind_m[3] & o) | {asel_m, 26'h0};
    pu = pu & ~{asel_m, 26'h0};
    for (int i = 0; i < 34; i++) lvl[i] = !oen[i] ? o[i] : (pu[i] | ext[i]);
    g = lvl & ~{asel_m, 26'h0} & ~(stby ? ~kind_m[4] : 34'h0);
    cmp(64'(poen), 64'(oen));
    cmp(64'(po & ~oen), 64'(o & ~oen));
    cmp(64'(ppu), 64'(pu));
    cmp(64'({rxd, sckin}), 64'({g[17:14], g[9:6]}));
    cmp(64'(dreq), 64'(g[20:18] & func_m[20:18]));
    cmp(64'({asw, dac}), 64'({asel_m, dac_m}));
    rd_chk(5'h0A, g[31:0]);
    rd_chk(5'h0B, {30'h0, g[33:32]});
  endtask

  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // **************************************************************
  // main sequence: reset values, then random rounds
  // **************************************************************
  initial begin
    foreach (kind_m[k]) kind_m[k] = '0;
    func_m = '0;
    asel_m = '0;
    dac_m = '0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd_all();
    check_all();
    for (int r = 0; r < 40; r++) begin
      @(posedge clk);
      rnd = $random(seed);
      ext[31:0] <= rnd;
      rnd = $random(seed);
      ext[33:32] <= rnd[1:0];
      {stby, pg, sck, tmr, tx, acc, dend} <= rnd[25:2];
      // includes refused level words and an unmapped word
      for (int a = 0; a < 16; a++) begin
        rnd = $random(seed);
        // receive and request pins kept as inputs by software
        if (a == 2) rnd = rnd & 32'hFFE03FFF;
        wr_reg(5'(a), rnd);
      end
      check_all();
      rd_all();
    end
    stop_test();
  end

  // hang guard: a run this long counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end
endmodule // peripheral_pin_multiplexer_tb

`default_nettype wire
